// >>> common/lawwd_pkg.sv
// Constants, register map and types for the load aware window watchdog.
// Assumes a single 40 MHz system clock and an APB master with 32-bit data.
// Notes on behaviour
// (RULE1) Straps both low give a 96 ms service timeout, first strap high and second low give 48 ms.
// (RULE2) First strap low and second high give 32 ms, both straps high give 16 ms.
// (RULE3) A strap change is only taken once it has stood for the 150 us setup and hold time.
// (RULE4) The controller holds each trigger level for at least 1 us so the pulse is seen.
// (RULE5) A trigger pin held in the disable band past the filter time turns the watchdog off, leaving it turns it on.
// (RULE6) A disable band condition under 100 us changes nothing, one lasting 500 us always completes the change.
// (RULE7) While the load current shows power save the watchdog is inactive and never pulls the fault pin low; a fault pulse already begun still completes.
// (RULE8) The load dependent inactive state is entered only after low current has lasted the full maximum filter time.
// (RULE9) A low current indication no longer than the minimum filter time always leaves the watchdog active.
// (RULE10) Return from load dependent inactive to active uses the same dwell filtering as entry.
// (RULE11) Each falling edge on the trigger input is a service that restarts the running timeout.
// (RULE12) The load current filter times are 100 us minimum and 500 us maximum.
// (RULE13) A missed service drives the fault pin low for 8 ms.
// (RULE14) After reset release an ignore window of 16 ms runs before the first timeout starts.
// (RULE15) All times are counted in system clock cycles and every pin input is synchronised first.
// (RULE16) A new strap selection takes effect at the start of the next timeout period only.
package lawwd_pkg;

	localparam int CLK_HZ = 40000000;
	localparam int CLK_MHZ = CLK_HZ / 1000000;

	// Times in microseconds.
	localparam int TMO_96_US = 96000;
	localparam int TMO_48_US = 48000;
	localparam int TMO_32_US = 32000;
	localparam int TMO_16_US = 16000;
	localparam int FAULT_LOW_US = 8000;
	localparam int IGNORE_US = 16000;
	localparam int FILTER_MIN_US = 100;
	localparam int FILTER_MAX_US = 500;
	localparam int STRAP_HOLD_US = 150;
	localparam int TRIG_PULSE_US = 1;

	// Cycle counts at the system clock rate.
	localparam int TMO_96_CYC = TMO_96_US * CLK_MHZ;
	localparam int TMO_48_CYC = TMO_48_US * CLK_MHZ;
	localparam int TMO_32_CYC = TMO_32_US * CLK_MHZ;
	localparam int TMO_16_CYC = TMO_16_US * CLK_MHZ;
	localparam int FAULT_LOW_CYC = FAULT_LOW_US * CLK_MHZ;
	localparam int IGNORE_CYC = IGNORE_US * CLK_MHZ;
	localparam int FILTER_MIN_CYC = FILTER_MIN_US * CLK_MHZ;
	localparam int FILTER_MAX_CYC = FILTER_MAX_US * CLK_MHZ;
	localparam int STRAP_HOLD_CYC = STRAP_HOLD_US * CLK_MHZ;
	localparam int TRIG_PULSE_CYC = TRIG_PULSE_US * CLK_MHZ;
	// Half the least pulse, so a legal 1 us pulse survives synchroniser jitter.
	localparam int TRIG_FILT_CYC = TRIG_PULSE_CYC / 2;

	// Register byte offsets.
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h04;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0c;

	// Event bit positions, shared by status, clear and enable.
	localparam int EV_TIMEOUT = 0;
	localparam int EV_DEACT = 1;
	localparam int EV_REACT = 2;
	localparam int EV_SERVICE = 3;
	localparam int EV_W = 4;

	localparam logic [EV_W-1:0] IRQ_ENABLE_RST = 4'h0;

	typedef enum logic [1:0] {
		ST_IGNORE = 2'b00,
		ST_SERVICE = 2'b01,
		ST_FAULT = 2'b10,
		ST_INACTIVE = 2'b11
	} lawwd_state_e;

endpackage

// >>> rtl/lawwd_sync.sv
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit coherence is not kept.
`timescale 1ns/1ps
module lawwd_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} lawwd_sync_s;

	lawwd_sync_s r;
	lawwd_sync_s next_r;

	always_comb begin
		next_r.s1 = async_in;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign sync_out = r.s2;
endmodule

// >>> rtl/lawwd_dwell.sv
// Dwell filter: the output follows the input only after the input has
// differed from it for DWELL consecutive cycles.
// Assumes a synchronised input on the same clock.
`timescale 1ns/1ps
module lawwd_dwell #(
	parameter int WIDTH = 1,
	parameter int DWELL = 20000,
	parameter int CNT_W = 16
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] level_in,
	output logic [WIDTH-1:0] level_out
);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(DWELL - 1);

	typedef struct packed {
		logic [WIDTH-1:0] filt;
		logic [CNT_W-1:0] cnt;
	} lawwd_dwell_s;

	lawwd_dwell_s r;
	lawwd_dwell_s next_r;

	always_comb begin
		next_r = r;
		// Any bounce back to the held value restarts the dwell from zero.
		if (level_in == r.filt) begin
			next_r.cnt = '0;
		end else if (r.cnt == LAST) begin
			next_r.filt = level_in;
			next_r.cnt = '0;
		end else begin
			next_r.cnt = r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign level_out = r.filt;
endmodule

// >>> rtl/lawwd_top.sv
// Watchdog supervisor with strap selected timeout, load and pin based
// deactivation, open-drain fault output and an APB register slave.
// Assumes pins and analog comparator indications arrive asynchronously.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module lawwd_top #(
	parameter int CNT_W = 22,
	parameter int TMO_96 = lawwd_pkg::TMO_96_CYC,
	parameter int TMO_48 = lawwd_pkg::TMO_48_CYC,
	parameter int TMO_32 = lawwd_pkg::TMO_32_CYC,
	parameter int TMO_16 = lawwd_pkg::TMO_16_CYC,
	parameter int FAULT_LOW = lawwd_pkg::FAULT_LOW_CYC,
	parameter int IGNORE = lawwd_pkg::IGNORE_CYC,
	parameter int FILTER_MAX = lawwd_pkg::FILTER_MAX_CYC,
	parameter int STRAP_HOLD = lawwd_pkg::STRAP_HOLD_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timeout_strap_a,
	input wire logic timeout_strap_b,
	input wire logic service_trigger_in,
	input wire logic disable_band_level,
	input wire logic load_current_low,
	input wire logic fault_signal_in,
	output logic fault_signal_out,
	output logic fault_signal_oe,
	output logic irq
);
	import lawwd_pkg::*;

	localparam logic [CNT_W-1:0] LAST_96 = CNT_W'(TMO_96 - 1);
	localparam logic [CNT_W-1:0] LAST_48 = CNT_W'(TMO_48 - 1);
	localparam logic [CNT_W-1:0] LAST_32 = CNT_W'(TMO_32 - 1);
	localparam logic [CNT_W-1:0] LAST_16 = CNT_W'(TMO_16 - 1);
	localparam logic [CNT_W-1:0] LAST_FAULT = CNT_W'(FAULT_LOW - 1);
	localparam logic [CNT_W-1:0] LAST_IGNORE = CNT_W'(IGNORE - 1);
	localparam logic [5:0] LAST_TRIG = 6'(TRIG_FILT_CYC - 1);

	typedef struct packed {
		lawwd_state_e st;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] tmo_last;
		logic trig_lvl;
		logic [5:0] trig_cnt;
		logic [EV_W-1:0] irq_status;
		logic [EV_W-1:0] irq_enable;
		logic [15:0] svc_count;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic fault_oe;
		logic fault_out;
		logic irq;
	} lawwd_top_s;

	lawwd_top_s r;
	lawwd_top_s next_r;

	logic [4:0] raw_sync;
	logic trig_s;
	logic dis_s;
	logic load_s;
	logic fault_pin_s;
	logic [1:0] strap_s;
	logic [1:0] strap_f;
	logic dis_f;
	logic load_f;

	// RULE15
	lawwd_sync #(
		.WIDTH(5)
	) u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.async_in({fault_signal_in, load_current_low, disable_band_level, timeout_strap_b, timeout_strap_a}),
		.sync_out(raw_sync)
	);

	assign strap_s = raw_sync[1:0];
	assign dis_s = raw_sync[2];
	assign load_s = raw_sync[3];
	assign fault_pin_s = raw_sync[4];

	// The trigger has its own synchroniser so its edge path stays short.
	lawwd_sync #(
		.WIDTH(1)
	) u_sync_trig (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.async_in(service_trigger_in),
		.sync_out(trig_s)
	);

	// RULE3
	lawwd_dwell #(
		.WIDTH(2),
		.DWELL(STRAP_HOLD),
		.CNT_W(16)
	) u_strap_filt (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.level_in(strap_s),
		.level_out(strap_f)
	);

	// RULE5 RULE6
	lawwd_dwell #(
		.WIDTH(1),
		.DWELL(FILTER_MAX),
		.CNT_W(16)
	) u_dis_filt (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.level_in(dis_s),
		.level_out(dis_f)
	);

	// Entry and exit share one symmetric dwell. RULE8 RULE9 RULE10 RULE12
	lawwd_dwell #(
		.WIDTH(1),
		.DWELL(FILTER_MAX),
		.CNT_W(16)
	) u_load_filt (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.level_in(load_s),
		.level_out(load_f)
	);

	logic inactive;
	logic trig_fall;
	logic [CNT_W-1:0] sel_last;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] clr;
	logic access;
	logic mapped;
	logic [31:0] rdata;

	always_comb begin
		next_r = r;
		ev = '0;
		clr = '0;
		trig_fall = 1'b0;
		inactive = load_f | dis_f;

		// Levels shorter than half the least pulse are treated as glitches. RULE4
		if (trig_s == r.trig_lvl) begin
			next_r.trig_cnt = '0;
		end else if (r.trig_cnt == LAST_TRIG) begin
			next_r.trig_lvl = trig_s;
			next_r.trig_cnt = '0;
			trig_fall = r.trig_lvl;
		end else begin
			next_r.trig_cnt = r.trig_cnt + 1'b1;
		end

		unique case (strap_f)
			2'b00: sel_last = LAST_96; // RULE1
			2'b01: sel_last = LAST_48; // RULE1
			2'b10: sel_last = LAST_32; // RULE2
			2'b11: sel_last = LAST_16; // RULE2
		endcase

		next_r.cnt = r.cnt + 1'b1;
		unique case (r.st)
			ST_IGNORE: begin
				if (inactive) begin
					next_r.st = ST_INACTIVE; // RULE7
					next_r.cnt = '0;
					ev[EV_DEACT] = 1'b1;
				end else if (r.cnt == LAST_IGNORE) begin
					next_r.st = ST_SERVICE; // RULE14
					next_r.cnt = '0;
					next_r.tmo_last = sel_last; // RULE16
				end
			end
			ST_SERVICE: begin
				if (inactive) begin
					next_r.st = ST_INACTIVE; // RULE7
					next_r.cnt = '0;
					ev[EV_DEACT] = 1'b1;
				end else if (trig_fall) begin
					next_r.cnt = '0; // RULE11
					next_r.tmo_last = sel_last; // RULE16
					next_r.svc_count = r.svc_count + 1'b1;
					ev[EV_SERVICE] = 1'b1;
				end else if (r.cnt == r.tmo_last) begin
					next_r.st = ST_FAULT; // RULE13
					next_r.cnt = '0;
					next_r.fault_oe = 1'b1;
					ev[EV_TIMEOUT] = 1'b1;
				end
			end
			ST_FAULT: begin
				// A pulse already begun runs to its full length even if the
				// watchdog goes inactive meanwhile, so the controller sees a
				// complete reset request.
				if (r.cnt == LAST_FAULT) begin
					next_r.fault_oe = 1'b0; // RULE13
					next_r.cnt = '0;
					if (inactive) begin
						next_r.st = ST_INACTIVE;
						ev[EV_DEACT] = 1'b1;
					end else begin
						next_r.st = ST_IGNORE;
					end
				end
			end
			ST_INACTIVE: begin
				next_r.cnt = '0; // RULE7
				if (!inactive) begin
					next_r.st = ST_IGNORE;
					ev[EV_REACT] = 1'b1;
				end
			end
		endcase

		// APB slave: one wait state, the write acts at the edge that sees pready.
		access = psel & penable;
		mapped = (paddr == OFS_IRQ_STATUS) || (paddr == OFS_IRQ_CLEAR) ||
			(paddr == OFS_IRQ_ENABLE) || (paddr == OFS_STATE);
		unique case (paddr)
			OFS_IRQ_STATUS: rdata = {28'h0, r.irq_status};
			OFS_IRQ_ENABLE: rdata = {28'h0, r.irq_enable};
			OFS_STATE: rdata = {r.svc_count, 8'h0, r.trig_lvl, fault_pin_s, dis_f, load_f, strap_f, r.st};
			default: rdata = 32'h0;
		endcase
		if (access && !r.pready) begin
			next_r.pready = 1'b1;
			next_r.pslverr = !mapped;
			next_r.prdata = pwrite ? 32'h0 : rdata;
		end else begin
			next_r.pready = 1'b0;
			next_r.pslverr = 1'b0;
			next_r.prdata = 32'h0;
		end
		if (access && r.pready && pwrite) begin
			if (paddr == OFS_IRQ_CLEAR) begin
				clr = pwdata[EV_W-1:0];
			end
			if (paddr == OFS_IRQ_ENABLE) begin
				next_r.irq_enable = pwdata[EV_W-1:0];
			end
		end

		// A new event wins over a clear in the same cycle.
		next_r.irq_status = (r.irq_status & ~clr) | ev;
		next_r.irq = |(next_r.irq_status & next_r.irq_enable);
		next_r.fault_out = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
			r.st <= ST_IGNORE;
			r.tmo_last <= LAST_96;
			r.irq_enable <= IRQ_ENABLE_RST;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign fault_signal_out = r.fault_out;
	assign fault_signal_oe = r.fault_oe;
	assign irq = r.irq;
endmodule

// >>> sim/lawwd_top_checker.sv
// Port checker for the watchdog top: bus answer timing and fault pin timing.
// Assumes the counts handed on by the bind are those of the bound instance.
`timescale 1ns/1ps
module lawwd_top_checker #(
	parameter int TMO_16 = 160,
	parameter int FAULT_LOW = 80,
	parameter int IGNORE = 160,
	parameter int FILTER_MAX = 50
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic load_current_low,
	input wire logic disable_band_level,
	input wire logic fault_signal_out,
	input wire logic fault_signal_oe
);
	int hc;
	int lc;
	int oc;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hc <= 0;
			lc <= 0;
			oc <= 0;
		end else begin
			hc <= fault_signal_oe ? hc + 1 : 0;
			lc <= fault_signal_oe ? 0 : lc + 1;
			oc <= (load_current_low || disable_band_level) ? oc + 1 : 0;
		end
	end
	chk_ready_once: assert property (pready |=> !pready) else $error("pready held");
	chk_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	chk_err_addr: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
		else $error("pslverr wrong");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
	chk_od_drive: assert property (fault_signal_out == 1'b0) else $error("fault drive high");
	chk_low_time: assert property ($fell(fault_signal_oe) |-> hc == FAULT_LOW)
		else $error("fault length");
	chk_ignore_gap: assert property ($rose(fault_signal_oe) |-> lc >= IGNORE + TMO_16 - 2)
		else $error("fault too soon");
	chk_quiet_off: assert property (oc > FILTER_MAX + 8 |-> !$rose(fault_signal_oe))
		else $error("fault while off");
	cover property ($rose(fault_signal_oe));
	cover property (pslverr);
	cover property (oc == FILTER_MAX + 9);
endmodule
bind lawwd_top lawwd_top_checker #(.TMO_16(TMO_16), .FAULT_LOW(FAULT_LOW), .IGNORE(IGNORE),
	.FILTER_MAX(FILTER_MAX)) u_chk (.clk_sys, .rstn, .psel, .penable, .paddr, .prdata, .pready,
	.pslverr, .load_current_low, .disable_band_level, .fault_signal_out, .fault_signal_oe);

// >>> sim/lawwd_mcu_model.sv
// Microcontroller model: toggles the trigger pin and counts fault pulses.
// Assumes the fault pin level is the resolved open-drain wire.
`timescale 1ns/1ps
module lawwd_mcu_model (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic [15:0] half,
	input wire logic fault_pin,
	output logic service_trigger_in,
	output int faults
);
	int cnt = 0;
	int n_fall = 0;
	logic pin_q = 1'b1;
	logic trig_q = 1'b0;
	assign service_trigger_in = trig_q;
	assign faults = n_fall;
	always @(posedge clk_sys) begin
		pin_q <= fault_pin;
		if (pin_q && !fault_pin)
			n_fall <= n_fall + 1;
		// Each level stands half cycles; the bench keeps half at 40 or more.
		cnt <= (run && cnt < half - 1) ? cnt + 1 : 0;
		if (run && cnt == half - 1)
			trig_q <= !trig_q;
	end
endmodule

// >>> sim/lawwd_top_tb.sv
// Testbench of the watchdog top with shortened counts.
// Assumes the microcontroller model and the bound checker.
`timescale 1ns/1ps
module lawwd_top_tb;
	import lawwd_pkg::*;
	localparam int TM [4] = '{960, 480, 320, 160};
	localparam int IGN = 160;
	localparam int FLT = 80;
	logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, rd_e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, fault_signal_out, fault_signal_oe, irq, service_trigger_in;
	logic timeout_strap_a = 0, timeout_strap_b = 0, disable_band_level = 0, load_current_low = 0;
	logic [15:0] half = 16'd40;
	wire logic fault_pin = fault_signal_oe ? fault_signal_out : 1'b1;
	int n_fail = 0, checks_done = 0, faults, n;
	lawwd_top #(.TMO_96(TM[0]), .TMO_48(TM[1]), .TMO_32(TM[2]), .TMO_16(TM[3]), .FAULT_LOW(FLT),
		.IGNORE(IGN), .FILTER_MAX(50), .STRAP_HOLD(30)) u_lawwd_top (.clk_sys, .rstn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timeout_strap_a, .timeout_strap_b,
		.service_trigger_in, .disable_band_level, .load_current_low, .fault_signal_in(fault_pin),
		.fault_signal_out, .fault_signal_oe, .irq);
	lawwd_mcu_model u_lawwd_mcu_model (.clk_sys, .run, .half, .fault_pin, .service_trigger_in, .faults);
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk_sys);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++)
			@(posedge clk_sys);
		if (k == 20) begin
			check(1'b0, 1'b1);
			wrap_up();
		end
		q = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic st(input logic [1:0] x);
		apb(1'b0, OFS_STATE, 32'h0);
		check(q[1:0], x);
	endtask
	task automatic ic(input logic x);
		tick(2);
		check(irq, x);
	endtask
	task automatic wait_oe(input logic lvl, input int lim);
		for (n = 1; n <= lim; n++) begin
			@(posedge clk_sys);
			if (fault_signal_oe === lvl)
				return;
		end
		n_fail++;
		wrap_up();
	endtask
	task automatic do_reset;
		rstn <= 1'b0;
		tick(10);
		rstn <= 1'b1;
	endtask
	task automatic near(input int seen, input int exp);
		check(seen > exp - 4 && seen < exp + 4, 1'b1);
	endtask
	task automatic t_regs;
		apb(1'b0, OFS_IRQ_ENABLE, 32'h0);
		check(q, 32'(IRQ_ENABLE_RST));
		apb(1'b0, 8'h10, 32'h0);
		check({q[30:0], rd_e}, 32'h1);
		apb(1'b1, OFS_IRQ_ENABLE, 32'h5);
		apb(1'b0, OFS_IRQ_ENABLE, 32'h0);
		check(q, 32'h5);
		st(ST_IGNORE);
	endtask
	task automatic t_tmo;
		int g;
		for (int i = 0; i < 4; i++) begin
			timeout_strap_a <= i[0];
			timeout_strap_b <= i[1];
			do_reset();
			g = 0;
			if (i == 0) begin
				// A strap blip shorter than the hold time must not shorten the period.
				timeout_strap_b <= 1'b1;
				tick(10);
				timeout_strap_b <= 1'b0;
				g = 10;
			end
			wait_oe(1'b1, 1500);
			near(n + g, IGN + TM[i]);
			wait_oe(1'b0, 200);
			check(n, FLT);
		end
		tick(IGN + 40);
		timeout_strap_a <= 1'b0;
		timeout_strap_b <= 1'b0;
		wait_oe(1'b1, 1500);
		near(n + 40, TM[3]);
		wait_oe(1'b0, 200);
		wait_oe(1'b1, 1500);
		near(n, IGN + TM[0]);
	endtask
	task automatic t_svc;
		int f;
		do_reset();
		run <= 1'b1;
		f = faults;
		tick(IGN + 1500);
		check(faults - f, 0);
		st(ST_SERVICE);
		check(q[31:16] > 16'h000c, 1'b1);
		apb(1'b1, OFS_IRQ_ENABLE, 32'h1);
		// Falling edges now come only every 1200 cycles, past the 960 cycle period.
		half <= 16'd600;
		wait_oe(1'b1, 2000);
		ic(1'b1);
		st(ST_FAULT);
		check(q[6], 1'b0);
		apb(1'b0, OFS_IRQ_STATUS, 32'h0);
		check(q, 32'h9);
		run <= 1'b0;
	endtask
	task automatic t_load;
		do_reset();
		apb(1'b1, OFS_IRQ_ENABLE, 32'h2);
		tick(IGN);
		load_current_low <= 1'b1;
		tick(30);
		load_current_low <= 1'b0;
		wait_oe(1'b1, 1100);
		wait_oe(1'b0, 200);
		load_current_low <= 1'b1;
		tick(40);
		st(ST_IGNORE);
		tick(20);
		st(ST_INACTIVE);
		apb(1'b0, OFS_IRQ_STATUS, 32'h0);
		check(q, 32'h3);
		ic(1'b1);
		apb(1'b1, OFS_IRQ_ENABLE, 32'h0);
		ic(1'b0);
		apb(1'b1, OFS_IRQ_ENABLE, 32'h2);
		ic(1'b1);
		apb(1'b1, OFS_IRQ_CLEAR, 32'h2);
		ic(1'b0);
		apb(1'b0, OFS_IRQ_STATUS, 32'h0);
		check(q, 32'h1);
		tick(1000);
		check(fault_signal_oe, 1'b0);
		load_current_low <= 1'b0;
		tick(30);
		st(ST_INACTIVE);
		tick(40);
		st(ST_IGNORE);
		apb(1'b1, OFS_IRQ_STATUS, 32'h0);
		apb(1'b0, OFS_IRQ_STATUS, 32'h0);
		check(q, 32'h5);
	endtask
	task automatic t_dis;
		half <= 16'd40;
		do_reset();
		run <= 1'b1;
		tick(IGN + 20);
		disable_band_level <= 1'b1;
		tick(30);
		disable_band_level <= 1'b0;
		tick(60);
		st(ST_SERVICE);
		run <= 1'b0;
		disable_band_level <= 1'b1;
		tick(70);
		st(ST_INACTIVE);
		tick(600);
		disable_band_level <= 1'b0;
		tick(70);
		st(ST_IGNORE);
	endtask
	initial begin
		do_reset();
		t_regs();
		t_tmo();
		t_svc();
		t_load();
		t_dis();
		wrap_up();
	end
	initial begin
		tick(100000);
		n_fail++;
		wrap_up();
	end
endmodule
